// file: amrp_params.svh
`ifndef AMRP_PARAMS_SVH
`define AMRP_PARAMS_SVH

// Register addresses
`define AMRP_ADDR_STATUS   8'h01
`define AMRP_ADDR_CONFIG   8'h02
`define AMRP_ADDR_OSR      8'h08
`define AMRP_ADDR_IFACE    8'h09
// Field positions
`define AMRP_STAT_RESET_BIT 7
`define AMRP_CFG_PWR_MSB    1
`define AMRP_CFG_PWR_LSB    0
// Reset values
`define AMRP_CONFIG_RST    8'h00
`define AMRP_OSR_RST       4'h0
`define AMRP_IFACE_RST     8'h00
// Oversample pin code for software mode
`define AMRP_OS_SOFTWARE   3'h7
// Highest ratio code per mode (log2 of ratio)
`define AMRP_OSR_HW_MAX    4'h6
`define AMRP_OSR_SW_MAX    4'h8
// Lane counts
`define AMRP_HW_LANES      4'h2
// Timing, clock period in ns
`define AMRP_CLK_NS        100
`define AMRP_PART_MIN_NS   55
`define AMRP_PART_MAX_NS   2000
`define AMRP_FULL_MIN_NS   3200
`define AMRP_PART_SETUP_NS 50
`define AMRP_FULL_SETUP_NS 274000
// Cycle counts: least rounds up, longest rounds down
`define AMRP_PART_MIN_CYC   ((`AMRP_PART_MIN_NS + `AMRP_CLK_NS - 1) / `AMRP_CLK_NS)
`define AMRP_PART_MAX_CYC   (`AMRP_PART_MAX_NS / `AMRP_CLK_NS)
`define AMRP_PART_SETUP_CYC ((`AMRP_PART_SETUP_NS + `AMRP_CLK_NS - 1) / `AMRP_CLK_NS)
`define AMRP_FULL_SETUP_CYC ((`AMRP_FULL_SETUP_NS + `AMRP_CLK_NS - 1) / `AMRP_CLK_NS)
// Pin fall to setup start: two sync stages plus the classify edge
`define AMRP_SYNC_LAT_CYC   3
`define AMRP_CNT_W          12

`endif

// file: amrp_pkg.sv
package amrp_pkg;
  typedef enum logic [1:0] {
    AMRP_PWR_NORMAL,
    AMRP_PWR_STANDBY,
    AMRP_PWR_AUTOSTBY,
    AMRP_PWR_SHUTDOWN
  } amrp_pwr_e;
  typedef logic [7:0] amrp_byte_t;
endpackage

// file: amrp_ctrl.sv
`timescale 1ns/1ps
`include "amrp_params.svh"
// Contract
// [RULE1] Oversample pins 000..110 decode to none, 2, 4, 8, 16, 32, 64.
// [RULE2] All oversample pins high selects software mode with register configuration.
// [RULE3] Hardware mode configuration comes from range, oversample and standby pins.
// [RULE4] Reference pin high enables internal reference; low expects an external one.
// [RULE5] After reset release the reference mode follows the reference pin.
// [RULE6] Reference and interface choice come from pins in both modes.
// [RULE7] Ratio at most 64 in hardware mode, up to 256 in software.
// [RULE8] Two data lines in hardware mode; 1, 2, 4 or 8 in software.
// [RULE9] Hardware mode uses one range for all channels; software per channel.
// [RULE10] Calibration and diagnostics only available in software mode.
// [RULE11] Host holds reset 55 ns to 2 us for a partial reset.
// [RULE12] Ready 50 ns after partial reset release.
// [RULE13] Host holds reset at least 3.2 us for a full reset.
// [RULE14] Full reset reconfigures within 274 us; host waits before converting.
// [RULE15] Partial reset reinitialises filter, CRC, converters and data mode.
// [RULE16] Any completed reset sets status bit 7 at address 0x01.
// [RULE17] Conversion in progress is discarded when a partial reset completes.
// [RULE18] Partial reset keeps registers and latched configuration.
// [RULE19] Full reset restores defaults, discards result, relatches mode and interface.
// [RULE20] Hardware mode: standby pin high normal; low gives standby or shutdown by range.
// [RULE21] Software mode power state from config register bits 1:0.
// [RULE22] Power field: 00 normal, 01 standby, 10 autostandby, 11 shutdown.
// [RULE23] Autostandby sleeps on busy fall, wakes on next conversion start rise.
// [RULE24] Oversample pins latched on each busy fall and each full reset.
// [RULE25] Host applies full reset after about 10 ms when leaving shutdown.
// [RULE26] Reset high time is measured and classified at its falling edge.
// [RULE27] Too-short pulses ignored; widths between partial and full limits act full.
module amrp_ctrl (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Configuration pins
  input  wire logic              oversample_select_msb,
  input  wire logic              oversample_select_mid,
  input  wire logic              oversample_select_lsb,
  input  wire logic              range_pin,
  input  wire logic              standby_request_pin,
  input  wire logic              reference_select_pin,
  input  wire logic              interface_type_pin,
  // Device reset pin and conversion pins
  input  wire logic              reset_pin,
  input  wire logic              conversion_start_pin,
  input  wire logic              busy_in,
  // Register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire amrp_pkg::amrp_byte_t reg_wdata,
  output logic      [7:0]        reg_rdata,
  // Mode and configuration outputs
  output logic                   software_mode,
  output logic      [3:0]        oversample_log2,
  output logic                   internal_ref_en,
  output logic                   parallel_iface,
  output logic      [3:0]        data_lanes,
  output logic                   range_10v_all,
  output logic                   calib_access_en,
  output amrp_pkg::amrp_pwr_e    power_state,
  // Reset outputs
  output logic                   partial_reset_pulse,
  output logic                   full_reset_pulse,
  output logic                   result_discard,
  output logic                   device_ready
);
  import amrp_pkg::*;

  typedef enum logic [1:0] {AMRP_IDLE, AMRP_MEASURE, AMRP_SETUP} amrp_rst_e;

  // Input synchronisers, two stages
  // busy_in comes from logic on this clock and skips them
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic [8:0] pins_async;
  assign pins_async = {oversample_select_msb, oversample_select_mid, oversample_select_lsb, range_pin,
                       standby_request_pin, reference_select_pin, interface_type_pin, reset_pin,
                       conversion_start_pin};
  always_ff @(posedge ref_clk) begin
    sync1_reg <= pins_async;
    sync2_reg <= sync1_reg;
  end

  logic [2:0] os_pins;
  logic       range_s;
  logic       standby_request_pin_s;
  logic       refsel_s;
  logic       iface_s;
  logic       rst_pin_s;
  logic       cnv_s;
  assign os_pins   = sync2_reg[8:6];
  assign range_s   = sync2_reg[5];
  assign standby_request_pin_s    = sync2_reg[4];
  assign refsel_s  = sync2_reg[3];
  assign iface_s   = sync2_reg[2];
  assign rst_pin_s = sync2_reg[1];
  assign cnv_s     = sync2_reg[0];

  // Edge detectors on synchronised levels and on busy_in directly
  // Cleared to the pins' idle low level, so no false edge after reset
  logic rst_pin_d_reg;
  logic cnv_d_reg;
  logic busy_d_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_pin_d_reg <= 1'b0;
      cnv_d_reg     <= 1'b0;
      busy_d_reg    <= 1'b0;
    end else begin
      rst_pin_d_reg <= rst_pin_s;
      cnv_d_reg     <= cnv_s;
      busy_d_reg    <= busy_in;
    end
  end

  logic rst_fall;
  logic cnv_rise;
  logic busy_fall;
  assign rst_fall  = rst_pin_d_reg & ~rst_pin_s;
  assign cnv_rise  = cnv_s & ~cnv_d_reg;
  assign busy_fall = busy_d_reg & ~busy_in;

  // Reset pulse width measurement and classification
  amrp_rst_e             rst_state_reg;
  amrp_rst_e             rst_state_next;
  logic [`AMRP_CNT_W-1:0] width_cnt_reg;
  logic [`AMRP_CNT_W-1:0] width_cnt_next;
  logic [`AMRP_CNT_W-1:0] setup_cnt_reg;
  logic [`AMRP_CNT_W-1:0] setup_cnt_next;
  logic                  is_partial;
  logic                  is_full;
  logic                  too_short;
  logic                  do_partial;
  logic                  do_full;
  logic                  width_sat;
  logic                  reset_done;
  logic [`AMRP_CNT_W-1:0] part_setup_load;
  logic [`AMRP_CNT_W-1:0] full_setup_load;

  // Width classification at the synchronised falling edge

  assign width_sat  = (width_cnt_reg == {`AMRP_CNT_W{1'b1}});
  assign too_short  = (width_cnt_reg < `AMRP_CNT_W'(`AMRP_PART_MIN_CYC)); // [RULE27]
  assign is_partial = !too_short && (width_cnt_reg <= `AMRP_CNT_W'(`AMRP_PART_MAX_CYC)); // [RULE11]
  assign is_full    = !too_short && !is_partial; // [RULE13] [RULE27]
  assign do_partial = (rst_state_reg == AMRP_MEASURE) && rst_fall && is_partial; // [RULE26]
  assign do_full    = (rst_state_reg == AMRP_MEASURE) && rst_fall && is_full; // [RULE26]
  assign reset_done = do_partial || do_full; // [RULE16]

  // Setup loads; full setup shortened by the synchroniser latency to meet the limit
  assign part_setup_load = `AMRP_CNT_W'(`AMRP_PART_SETUP_CYC); // [RULE12]
  assign full_setup_load = `AMRP_CNT_W'(`AMRP_FULL_SETUP_CYC - `AMRP_SYNC_LAT_CYC); // [RULE14]

  // Reset sequencer next state
  always_comb begin
    rst_state_next = rst_state_reg;
    width_cnt_next = width_cnt_reg;
    setup_cnt_next = setup_cnt_reg;
    case (rst_state_reg)
      AMRP_IDLE: begin
        if (rst_pin_s) begin
          rst_state_next = AMRP_MEASURE;
          width_cnt_next = `AMRP_CNT_W'(1);
        end
      end
      AMRP_MEASURE: begin
        if (rst_fall) begin
          if (do_partial) begin
            rst_state_next = AMRP_SETUP;
            setup_cnt_next = part_setup_load; // [RULE12]
          end else if (do_full) begin
            rst_state_next = AMRP_SETUP;
            setup_cnt_next = full_setup_load; // [RULE14]
          end else begin
            rst_state_next = AMRP_IDLE;
          end
        end else if (!width_sat) begin
          width_cnt_next = width_cnt_reg + `AMRP_CNT_W'(1);
        end
      end
      AMRP_SETUP: begin
        if (rst_pin_s) begin
          rst_state_next = AMRP_MEASURE;
          width_cnt_next = `AMRP_CNT_W'(1);
        end else if (setup_cnt_reg <= `AMRP_CNT_W'(1)) begin
          rst_state_next = AMRP_IDLE;
          setup_cnt_next = '0;
        end else begin
          setup_cnt_next = setup_cnt_reg - `AMRP_CNT_W'(1);
        end
      end
      default: rst_state_next = AMRP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_state_reg <= AMRP_IDLE;
      width_cnt_reg <= '0;
      setup_cnt_reg <= '0;
    end else begin
      rst_state_reg <= rst_state_next;
      width_cnt_reg <= width_cnt_next;
      setup_cnt_reg <= setup_cnt_next;
    end
  end

  // Latched configuration, relatched on full reset only; the oversample code is also latched on busy fall
  // Strap pending forces one latch on the first edge after reset
  logic       sw_mode_reg;
  logic       par_reg;
  logic [2:0] os_latch_reg;
  logic       strap_pending_reg;
  logic       relatch;
  assign relatch = strap_pending_reg | do_full; // [RULE19] [RULE18]
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_pending_reg <= 1'b1;
      sw_mode_reg       <= 1'b0;
      par_reg           <= 1'b0;
      os_latch_reg      <= 3'h0;
    end else begin
      strap_pending_reg <= 1'b0;
      if (relatch) begin
        sw_mode_reg <= (os_pins == `AMRP_OS_SOFTWARE); // [RULE2]
        par_reg     <= iface_s; // [RULE6]
      end
      if (relatch || busy_fall) begin
        os_latch_reg <= os_pins; // [RULE24]
      end
    end
  end

  // Registers: status and configuration, plus ratio and lane registers
  // Writes land only in software mode; a full reset wins over a write
  logic [7:0] config_reg;
  logic [3:0] osr_reg;
  logic [7:0] iface_reg;
  logic       reset_seen_reg;
  logic       status_read;
  assign status_read = reg_rd && (reg_addr == `AMRP_ADDR_STATUS);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      config_reg     <= `AMRP_CONFIG_RST;
      osr_reg        <= `AMRP_OSR_RST;
      iface_reg      <= `AMRP_IFACE_RST;
      reset_seen_reg <= 1'b0;
    end else begin
      if (do_full) begin
        config_reg <= `AMRP_CONFIG_RST; // [RULE19]
        osr_reg    <= `AMRP_OSR_RST;
        iface_reg  <= `AMRP_IFACE_RST;
      end else if (reg_wr && sw_mode_reg) begin
        if (reg_addr == `AMRP_ADDR_CONFIG) config_reg <= reg_wdata; // [RULE21]
        if (reg_addr == `AMRP_ADDR_OSR) osr_reg <= reg_wdata[3:0];
        if (reg_addr == `AMRP_ADDR_IFACE) iface_reg <= reg_wdata;
      end
      // Set wins over a read clear
      if (reset_done) reset_seen_reg <= 1'b1; // [RULE16]
      else if (status_read) reset_seen_reg <= 1'b0;
    end
  end

  // Register read mux
  logic [7:0] rdata_next;
  logic [7:0] status_val;
  assign status_val = 8'(reset_seen_reg) << `AMRP_STAT_RESET_BIT;
  assign rdata_next = (reg_addr == `AMRP_ADDR_STATUS) ? status_val :
                      (reg_addr == `AMRP_ADDR_CONFIG) ? config_reg :
                      (reg_addr == `AMRP_ADDR_OSR)    ? {4'h0, osr_reg} :
                      (reg_addr == `AMRP_ADDR_IFACE)  ? iface_reg : 8'h00;

  // Ratio decode: pin code is log2 of ratio
  function automatic logic [3:0] amrp_clip(input logic [3:0] v, input logic [3:0] max);
    amrp_clip = (v > max) ? max : v;
  endfunction
  logic [3:0] osr_next;
  assign osr_next = sw_mode_reg ? amrp_clip(osr_reg, `AMRP_OSR_SW_MAX) : // [RULE7]
                                  amrp_clip({1'b0, os_latch_reg}, `AMRP_OSR_HW_MAX); // [RULE1] [RULE3]

  // Lane count: 1,2,4,8 from two interface register bits in software mode
  logic [3:0] lanes_next;
  assign lanes_next = sw_mode_reg ? (4'h1 << iface_reg[1:0]) : `AMRP_HW_LANES; // [RULE8]

  // Power state selection
  logic       autostby_reg;
  amrp_pwr_e  pwr_field;
  amrp_pwr_e  pwr_next;
  assign pwr_field = amrp_pwr_e'(config_reg[`AMRP_CFG_PWR_MSB:`AMRP_CFG_PWR_LSB]); // [RULE22]
  always_comb begin
    if (!sw_mode_reg) begin
      if (standby_request_pin_s) pwr_next = AMRP_PWR_NORMAL; // [RULE20]
      else if (range_s) pwr_next = AMRP_PWR_STANDBY;
      else pwr_next = AMRP_PWR_SHUTDOWN;
    end else if (pwr_field == AMRP_PWR_AUTOSTBY) begin
      pwr_next = autostby_reg ? AMRP_PWR_STANDBY : AMRP_PWR_NORMAL; // [RULE23]
    end else begin
      pwr_next = pwr_field; // [RULE21]
    end
  end

  // Autostandby sleep flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      autostby_reg <= 1'b0;
    end else if (cnv_rise) begin
      autostby_reg <= 1'b0; // [RULE23]
    end else if (busy_fall) begin
      autostby_reg <= 1'b1;
    end
  end

  // Registered outputs
  // Ready looks at the next state so it rises with the return to idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata           <= 8'h00;
      software_mode       <= 1'b0;
      oversample_log2     <= 4'h0;
      internal_ref_en     <= 1'b0;
      parallel_iface      <= 1'b0;
      data_lanes          <= `AMRP_HW_LANES;
      range_10v_all       <= 1'b0;
      calib_access_en     <= 1'b0;
      power_state         <= AMRP_PWR_NORMAL;
      partial_reset_pulse <= 1'b0;
      full_reset_pulse    <= 1'b0;
      result_discard      <= 1'b0;
      device_ready        <= 1'b0;
    end else begin
      reg_rdata           <= reg_rd ? rdata_next : 8'h00;
      software_mode       <= sw_mode_reg;
      oversample_log2     <= osr_next;
      internal_ref_en     <= refsel_s; // [RULE4] [RULE5] [RULE6]
      parallel_iface      <= par_reg;
      data_lanes          <= lanes_next;
      range_10v_all       <= !sw_mode_reg && range_s; // [RULE9]
      calib_access_en     <= sw_mode_reg; // [RULE10]
      power_state         <= pwr_next;
      partial_reset_pulse <= do_partial; // [RULE15]
      full_reset_pulse    <= do_full; // [RULE19]
      result_discard      <= reset_done; // [RULE17]
      device_ready        <= (rst_state_next == AMRP_IDLE) && !strap_pending_reg; // [RULE12] [RULE14]
    end
  end
endmodule

// file: amrp_ctrl_props.sv
`timescale 1ns/1ps
module amrp_ctrl_props
  import amrp_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Mode and configuration
  input wire logic       software_mode,
  input wire logic [3:0] oversample_log2,
  input wire logic [3:0] data_lanes,
  input wire logic       range_10v_all,
  input wire logic       calib_access_en,
  input wire amrp_pwr_e  power_state,
  // Reset results
  input wire logic       partial_reset_pulse,
  input wire logic       full_reset_pulse,
  input wire logic       result_discard,
  input wire logic       device_ready
);
  // One clock domain for every property
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_ONE_KIND: assert property (!(partial_reset_pulse && full_reset_pulse))
    else $error("partial and full reset reported together");
  AST_PART_DISCARD: assert property (partial_reset_pulse |-> result_discard)
    else $error("partial reset kept the result");
  AST_FULL_DISCARD: assert property (full_reset_pulse |-> result_discard)
    else $error("full reset kept the result");
  AST_PART_READY: assert property (partial_reset_pulse |-> ##[0:4] device_ready)
    else $error("not ready soon after partial reset");
  AST_FULL_SETUP: assert property (full_reset_pulse |=> !device_ready [*8])
    else $error("ready too early after full reset");
  AST_CALIB: assert property (calib_access_en == software_mode)
    else $error("calibration access outside software mode");
  AST_HW_LANES: assert property (!software_mode && !$past(software_mode) |-> data_lanes == 4'h2)
    else $error("hardware mode lane count wrong");
  AST_HW_OSR: assert property (!software_mode && !$past(software_mode) |-> oversample_log2 <= 4'h6)
    else $error("hardware mode ratio above 64");
  AST_OSR_MAX: assert property (oversample_log2 <= 4'h8)
    else $error("ratio above 256");
  AST_SW_RANGE: assert property (software_mode && $past(software_mode) |-> !range_10v_all)
    else $error("common range flag in software mode");
  AST_NO_AUTO: assert property (power_state != AMRP_PWR_AUTOSTBY)
    else $error("autostandby shown as a power state");
  // Main scenarios reached
  COV_PART: cover property (partial_reset_pulse);
  COV_FULL: cover property (full_reset_pulse);
  COV_SHUT: cover property (power_state == AMRP_PWR_SHUTDOWN);
endmodule

bind amrp_ctrl amrp_ctrl_props u_props (.*);

// file: amrp_host.sv
`timescale 1ns/1ps
module amrp_host (
  // Clock
  input  wire logic ref_clk,
  // Pins toward the device
  output logic      reset_pin,
  output logic      busy_in,
  output logic      conversion_start_pin
);
  // Idle pin levels
  initial begin
    reset_pin = 1'b0;
    busy_in = 1'b0;
    conversion_start_pin = 1'b0;
  end
  // Reset pulse of n cycles, 5 for partial, 40 for full
  task automatic pulse_reset(input int n);
    @(negedge ref_clk);
    reset_pin = 1'b1;
    repeat (n) @(negedge ref_clk);
    reset_pin = 1'b0;
  endtask
  // Start rise, busy raised with it
  task automatic begin_conv();
    @(negedge ref_clk);
    conversion_start_pin = 1'b1;
    busy_in = 1'b1;
  endtask
  // Busy falls after three cycles, start drops
  task automatic end_conv();
    repeat (3) @(negedge ref_clk);
    busy_in = 1'b0;
    conversion_start_pin = 1'b0;
  endtask
  // Wait out setup before any conversion
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
endmodule

// file: amrp_ctrl_test.sv
`timescale 1ns/1ps
module amrp_ctrl_test;
  import amrp_pkg::*;
  logic       ref_clk, rst_n, range_pin, standby_request_pin, reference_select_pin;
  logic       interface_type_pin, reset_pin, conversion_start_pin, busy_in, reg_wr, reg_rd;
  logic       oversample_select_msb, oversample_select_mid, oversample_select_lsb;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       software_mode, internal_ref_en, parallel_iface, range_10v_all, calib_access_en;
  logic       partial_reset_pulse, full_reset_pulse, result_discard, device_ready;
  logic [3:0] oversample_log2, data_lanes;
  amrp_pwr_e  power_state;
  int         failures, n_tests, cyc;
  int         n_part, n_full, n_disc;

  amrp_ctrl dut (.*);
  amrp_host host (.*);

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // Count one-cycle reset pulses where they are settled
  always @(negedge ref_clk) begin
    if (partial_reset_pulse) n_part++;
    if (full_reset_pulse) n_full++;
    if (result_discard) n_disc++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    w(1);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    w(1);
    reg_wr = 1'b0;
  endtask
  // Read, mask and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    w(1);
    {reg_rd, reg_addr} = {1'b1, a};
    w(1);
    reg_rd = 1'b0;
    chk(reg_rdata & m, e);
  endtask
  // Main sequence
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, rst_n} = '0;
    {range_pin, standby_request_pin, reference_select_pin, interface_type_pin} = 4'hF;
    {oversample_select_msb, oversample_select_mid, oversample_select_lsb} = 3'h0;
    {failures, n_tests, cyc, n_part, n_full, n_disc} = '0;
    w(20);
    rst_n = 1'b1;
    w(6);
    chk(8'(software_mode), 8'h00);
    chk(8'(parallel_iface), 8'h01);
    chk(8'(data_lanes), 8'h02);
    chk(8'(range_10v_all), 8'h01);
    chk(8'(calib_access_en), 8'h00);
    chk(8'(internal_ref_en), 8'h01);
    reference_select_pin = 1'b0;
    w(5);
    chk(8'(internal_ref_en), 8'h00);
    for (int i = 0; i < 7; i++) begin
      {oversample_select_msb, oversample_select_mid, oversample_select_lsb} = i[2:0];
      w(4);
      host.begin_conv();
      host.end_conv();
      w(5);
      chk(8'(oversample_log2), 8'(i));
    end
    {oversample_select_msb, oversample_select_mid, oversample_select_lsb} = 3'h0;
    w(6);
    chk(8'(oversample_log2), 8'h06);
    standby_request_pin = 1'b0;
    w(5);
    chk(8'(power_state), 8'h01);
    range_pin = 1'b0;
    w(5);
    chk(8'(power_state), 8'h03);
    {standby_request_pin, range_pin, interface_type_pin} = 3'b110;
    w(5);
    chk(8'(power_state), 8'h00);
    host.pulse_reset(5);
    chk(8'(device_ready), 8'h00);
    w(8);
    chk(8'(device_ready), 8'h01);
    chk(8'(n_part), 8'h01);
    chk(8'(n_full), 8'h00);
    chk(8'(n_disc), 8'h01);
    chk(8'(parallel_iface), 8'h01);
    chk(8'(oversample_log2), 8'h06);
    rc(8'h01, 8'h80, 8'h80);
    rc(8'h01, 8'h80, 8'h00);
    wr(8'h02, 8'h03);
    rc(8'h02, 8'hFF, 8'h00);
    rc(8'h05, 8'hFF, 8'h00);
    // Longest partial width is still partial
    host.pulse_reset(20);
    w(8);
    chk(8'(n_part), 8'h02);
    chk(8'(n_full), 8'h00);
    {oversample_select_msb, oversample_select_mid, oversample_select_lsb} = 3'h7;
    host.pulse_reset(40);
    w(10);
    chk(8'(device_ready), 8'h00);
    chk(8'(n_full), 8'h01);
    chk(8'(n_part), 8'h02);
    host.settle(2760);
    chk(8'(device_ready), 8'h01);
    chk(8'(software_mode), 8'h01);
    chk(8'(calib_access_en), 8'h01);
    chk(8'(parallel_iface), 8'h00);
    chk(8'(internal_ref_en), 8'h00);
    chk(8'(range_10v_all), 8'h00);
    rc(8'h01, 8'h80, 8'h80);
    rc(8'h02, 8'hFF, 8'h00);
    // Every power code, autostandby through a conversion
    for (int i = 0; i < 4; i++) begin
      wr(8'h02, 8'(i));
      rc(8'h02, 8'h03, 8'(i));
      w(4);
      if (i != 2) begin
        chk(8'(power_state), 8'(i));
      end else begin
        host.begin_conv();
        host.end_conv();
        w(4);
        chk(8'(power_state), 8'h01);
        host.begin_conv();
        w(4);
        chk(8'(power_state), 8'h00);
        host.end_conv();
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h09, 8'(i));
      w(4);
      chk(8'(data_lanes), 8'(1 << i));
    end
    wr(8'h08, 8'h08);
    rc(8'h08, 8'h0F, 8'h08);
    host.begin_conv();
    host.end_conv();
    w(5);
    chk(8'(oversample_log2), 8'h08);
    wr(8'h02, 8'h01);
    host.pulse_reset(5);
    w(8);
    rc(8'h02, 8'h03, 8'h01);
    rc(8'h08, 8'h0F, 8'h08);
    chk(8'(software_mode), 8'h01);
    chk(8'(n_part), 8'h03);
    chk(8'(n_disc), 8'h04);
    print_verdict();
  end
endmodule
